// ===== include/ssdl_pkg.sv
// Purpose: shared constants for the serial word loader link and both ends
// Assumes: 250 MHz system clock, host-made link clock
// Notes:   all timing counts are derived from the printed times
package ssdl_pkg;
	localparam int unsigned WORD_W         = 16;
	localparam int unsigned BYTE_W         = 8;
	localparam int unsigned FIFO_DEPTH     = 8;
	localparam int unsigned NBITS_W        = 5;
	localparam int unsigned MCLK_PERIOD_NS = 4;
	localparam int unsigned SCLK_PERIOD_NS = 80;
	// half a link clock period in system cycles, at least one
	localparam int unsigned HALF_RAW       = SCLK_PERIOD_NS / (2 * MCLK_PERIOD_NS);
	localparam logic [7:0]  SCLK_HALF_CYC  = 8'((HALF_RAW < 1) ? 1 : HALF_RAW);
	localparam logic [3:0]  LAST_BIT       = 4'(WORD_W - 1);
	localparam logic [3:0]  LAST_BYTE_BIT  = 4'(BYTE_W - 1);
	localparam logic [15:0] CODE_RESET     = 16'h0000;
	localparam logic [4:0]  NBITS_FULL     = 5'h10;
	typedef logic [WORD_W-1:0] ssdl_word_t;
endpackage

// ===== include/ssdl_link_if.sv
// Purpose: link wires between host and converter word loader
// Assumes: all lines are one-way, driven by the host, or by the bench on its second link
// Notes:   no clocking block; the bench joins the two ends here
`timescale 1ns/1ns
interface ssdl_link_if;
	logic sclk;
	logic cs_n;
	logic din;
	logic load_update_n;
	modport host (output sclk, output cs_n, output din, output load_update_n);
	modport dev  (input sclk, input cs_n, input din, input load_update_n);
endinterface

// ===== verilog/ssdl_dev.sv
// Purpose: converter end: shift register on the link clock, converter register on i_mclk
// Assumes: host leaves select high a few system cycles between frames
// Notes:   shift register has no reset, it powers up unknown
`timescale 1ns/1ns
module ssdl_dev
	import ssdl_pkg::*;
#(
	parameter bit HAS_LOAD = 1'b1
) (
	input  wire logic        i_mclk,
	input  wire logic        i_rst,
	ssdl_link_if.dev         link,
	output logic [WORD_W-1:0] o_code,
	output logic             o_update
);
	ssdl_word_t shift_ff;
	ssdl_word_t code_ff;
	logic       cs_s1_ff;
	logic       cs_s2_ff;
	logic       cs_s3_ff;
	logic       ld_s1_ff;
	logic       ld_s2_ff;
	logic       ld_s3_ff;
	logic       upd_ff;
	logic       cs_rise;
	logic       ld_fall;
	logic       ld_low;
	logic       do_load;

	// link domain: capture only inside a frame, on the rising edge;
	// no reset so contents stay unknown until bits arrive
	always_ff @(posedge link.sclk) begin
		if (!link.cs_n) begin
			shift_ff <= {shift_ff[WORD_W-2:0], link.din};
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			cs_s1_ff <= 1'b1;
			cs_s2_ff <= 1'b1;
			cs_s3_ff <= 1'b1;
		end else begin
			cs_s1_ff <= link.cs_n;
			cs_s2_ff <= cs_s1_ff;
			cs_s3_ff <= cs_s2_ff;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			ld_s1_ff <= 1'b1;
			ld_s2_ff <= 1'b1;
			ld_s3_ff <= 1'b1;
		end else begin
			ld_s1_ff <= link.load_update_n;
			ld_s2_ff <= ld_s1_ff;
			ld_s3_ff <= ld_s2_ff;
		end
	end

	assign ld_low  = !HAS_LOAD || !ld_s2_ff;
	assign cs_rise = cs_s2_ff && !cs_s3_ff;
	assign ld_fall = HAS_LOAD && !ld_s2_ff && ld_s3_ff;
	// the shift register is frozen while select is high, so it is read
	// here as quasi-static data qualified by the synchronised select
	assign do_load = (cs_rise && ld_low) || (ld_fall && cs_s2_ff);

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			code_ff <= CODE_RESET;
		end else if (do_load) begin
			code_ff <= shift_ff;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			upd_ff <= 1'b0;
		end else begin
			upd_ff <= do_load;
		end
	end

	assign o_code   = code_ff;
	assign o_update = upd_ff;
endmodule

// ===== verilog/ssdl_host.sv
// Purpose: host end: word FIFO, bit ordering and padding, serial master
// Assumes: link clock is made here from i_mclk by a divider
// Notes:   data changes on falling link clock edges, clock idles low
`timescale 1ns/1ns
module ssdl_fifo
	import ssdl_pkg::*;
#(
	parameter int unsigned W     = WORD_W,
	parameter int unsigned DEPTH = FIFO_DEPTH
) (
	input  wire logic         i_mclk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_data,
	input  wire logic         i_valid,
	output logic              o_ready,
	output logic [W-1:0]      o_data,
	output logic              o_valid,
	input  wire logic         i_ready
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0]  mem_ff [DEPTH];
	logic [AW-1:0] wr_ff;
	logic [AW-1:0] rd_ff;
	logic [AW:0]   cnt_ff;
	logic          push;
	logic          pop;

	assign o_ready = cnt_ff != (AW+1)'(DEPTH);
	assign o_valid = cnt_ff != '0;
	assign push    = i_valid && o_ready;
	assign pop     = o_valid && i_ready;
	assign o_data  = mem_ff[rd_ff];

	always_ff @(posedge i_mclk) begin
		if (push) begin
			mem_ff[wr_ff] <= i_data;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			wr_ff  <= '0;
			rd_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) begin
				wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
			end
			if (pop) begin
				rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
			end
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// Function
// - converter register powers up all zeros
// - shift register not cleared, starts unknown
// - over-long frame keeps last sixteen bits
// - short frame shifts older bits up, keeps the rest
// - first load after power-up: full sixteen bits
// - narrow values padded with zeros at LSB end
// - sixteen-bit word, data stable at rising edge
// - update at frame end or by load input
// - most significant bit sent first
// - byte mode keeps select low across bytes
// - clock idles low, sample on first edge
// - data changes on falling edge, no glue
// - rising-edge-change masters need inverted clock
// - load input driven separately from select
// - shift only while select is low
// - select rise copies word when load low
// - load high while shifting, low-going updates
// - load held low gives update per frame
module ssdl_host
	import ssdl_pkg::*;
(
	input  wire logic               i_mclk,
	input  wire logic               i_rst,
	input  wire logic [WORD_W-1:0]  i_data,
	input  wire logic [NBITS_W-1:0] i_nbits,
	input  wire logic               i_lsb_first,
	input  wire logic               i_valid,
	output logic                    o_ready,
	input  wire logic               i_byte_mode,
	input  wire logic               i_sync_load,
	output logic                    o_busy,
	output logic                    o_done,
	ssdl_link_if.host               link
);
	typedef enum logic [3:0] {
		H_IDLE, H_LEAD, H_HIGH, H_LOW, H_GAP, H_TAIL, H_LOAD, H_LDHOLD, H_SPACE
	} ssdl_hstate_t;

	ssdl_hstate_t  st_ff;
	ssdl_word_t    word_in;
	ssdl_word_t    fifo_data;
	ssdl_word_t    shift_ff;
	logic          fifo_valid;
	logic          fifo_pop;
	logic [7:0]    div_ff;
	logic          tick;
	logic [3:0]    cnt_ff;
	logic          byte_ff;
	logic          sync_ff;
	logic          sclk_ff;
	logic          cs_n_ff;
	logic          dout_ff;
	logic          ld_n_ff;
	logic          done_ff;
	logic [4:0]    shamt;

	function automatic ssdl_word_t bit_rev(input ssdl_word_t w);
		ssdl_word_t r;
		r = '0;
		for (int i = 0; i < WORD_W; i++) begin
			r[i] = w[WORD_W-1-i];
		end
		return r;
	endfunction

	// nbits of zero means a full word; over-range is treated as full
	always_comb begin
		word_in = i_lsb_first ? bit_rev(i_data) : i_data;
		shamt   = 5'h00;
		if (i_lsb_first) begin
			word_in = word_in >> (NBITS_FULL - ((i_nbits == 5'h00 || i_nbits > NBITS_FULL)
				? NBITS_FULL : i_nbits));
		end
		if (i_nbits != 5'h00 && i_nbits < NBITS_FULL) begin
			shamt = NBITS_FULL - i_nbits;
		end
		word_in = word_in << shamt;
	end

	ssdl_fifo #(
		.W     (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) ssdl_fifo_i (
		.i_mclk  (i_mclk),
		.i_rst   (i_rst),
		.i_data  (word_in),
		.i_valid (i_valid),
		.o_ready (o_ready),
		.o_data  (fifo_data),
		.o_valid (fifo_valid),
		.i_ready (fifo_pop)
	);

	assign fifo_pop = (st_ff == H_IDLE) && fifo_valid;
	assign tick     = div_ff == SCLK_HALF_CYC - 8'h01;

	// free-running divider: every state move except leaving H_IDLE waits for a tick; the wait in H_LEAD can be shorter than a half period
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			div_ff <= 8'h00;
		end else begin
			div_ff <= tick ? 8'h00 : div_ff + 8'h01;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			st_ff    <= H_IDLE;
			shift_ff <= '0;
			cnt_ff   <= 4'h0;
			byte_ff  <= 1'b0;
			sync_ff  <= 1'b0;
			sclk_ff  <= 1'b0;
			cs_n_ff  <= 1'b1;
			dout_ff  <= 1'b0;
			ld_n_ff  <= 1'b1;
			done_ff  <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			unique case (st_ff)
				H_IDLE: begin
					sclk_ff <= 1'b0;
					if (fifo_valid) begin
						// load takes its mode level only as select falls, so a mode change
						// between frames never reads as a late load request
						ld_n_ff  <= !i_sync_load;
						// every frame is a full word, so even the first load
						// after power-up leaves no unknown bits behind
						shift_ff <= {fifo_data[WORD_W-2:0], 1'b0};
						dout_ff  <= fifo_data[WORD_W-1];
						cs_n_ff  <= 1'b0;
						cnt_ff   <= 4'h0;
						byte_ff  <= i_byte_mode;
						sync_ff  <= i_sync_load;
						st_ff    <= H_LEAD;
					end
				end
				H_LEAD, H_LOW: begin
					if (tick) begin
						sclk_ff <= 1'b1;
						st_ff   <= H_HIGH;
					end
				end
				H_HIGH: begin
					if (tick) begin
						// change data on the falling edge so it is settled a
						// half period before the next capture edge
						sclk_ff  <= 1'b0;
						dout_ff  <= shift_ff[WORD_W-1];
						shift_ff <= {shift_ff[WORD_W-2:0], 1'b0};
						cnt_ff   <= cnt_ff + 4'h1;
						if (cnt_ff == LAST_BIT) begin
							st_ff <= H_TAIL;
						end else if (byte_ff && cnt_ff == LAST_BYTE_BIT) begin
							st_ff <= H_GAP;
						end else begin
							st_ff <= H_LOW;
						end
					end
				end
				H_GAP: begin
					if (tick) begin
						st_ff <= H_LOW;
					end
				end
				H_TAIL: begin
					if (tick) begin
						cs_n_ff <= 1'b1;
						st_ff   <= sync_ff ? H_SPACE : H_LOAD;
					end
				end
				H_LOAD: begin
					if (tick) begin
						ld_n_ff <= 1'b0;
						st_ff   <= H_LDHOLD;
					end
				end
				H_LDHOLD: begin
					if (tick) begin
						ld_n_ff <= 1'b1;
						st_ff   <= H_SPACE;
					end
				end
				H_SPACE: begin
					// select stays high long enough for the far end to see it
					if (tick) begin
						done_ff <= 1'b1;
						st_ff   <= H_IDLE;
					end
				end
				default: begin
					st_ff <= H_IDLE;
				end
			endcase
		end
	end

	assign o_busy             = st_ff != H_IDLE;
	assign o_done             = done_ff;
	assign link.sclk          = sclk_ff;
	assign link.cs_n          = cs_n_ff;
	assign link.din           = dout_ff;
	assign link.load_update_n = ld_n_ff;
endmodule

// ===== test/ssdl_link_properties.sv
// Purpose: timing checks on the link between host and converter
// Assumes: host half period of 10 i_mclk cycles
// Notes:   every wire is sampled on i_mclk
`timescale 1ns/1ns
module ssdl_link_properties (
	input wire logic	i_mclk,
	input wire logic	i_rst,
	input wire logic	sclk,
	input wire logic	cs_n,
	input wire logic	din,
	input wire logic	load_update_n
);
	logic [4:0]	rises_ff;
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			rises_ff <= 5'h00;
		end else if (cs_n) begin
			rises_ff <= 5'h00;
		end else if ($rose(sclk)) begin
			rises_ff <= rises_ff + 5'h01;
		end
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	idle_clk_low_a: assert property (cs_n |-> !sclk)
		else $error("sclk active outside a frame");
	din_stable_a: assert property (sclk && $past(sclk) |-> $stable(din))
		else $error("din moved while sclk high");
	word_len_a: assert property ($rose(cs_n) |-> rises_ff == 5'h10)
		else $error("frame without sixteen rises");
	first_edge_a: assert property ($fell(cs_n) |-> ##[1:10] $rose(sclk))
		else $error("no first rise after select");
	half_high_a: assert property ($rose(sclk) |=> sclk [*8])
		else $error("sclk high phase short");
	half_low_a: assert property ($fell(sclk) |=> !sclk [*8])
		else $error("sclk low phase short");
	frame_gap_a: assert property ($rose(cs_n) |=> cs_n [*8])
		else $error("select gap too short");
	load_steady_a: assert property (!cs_n && sclk |-> $stable(load_update_n))
		else $error("load moved while shifting");
	load_after_a: assert property ($rose(cs_n) && load_update_n |-> ##[8:12] !load_update_n)
		else $error("load not lowered after frame");
	cover property ($rose(cs_n) && !load_update_n);
	cover property ($fell(load_update_n));
	cover property ($rose(cs_n));
endmodule

// ===== test/serial_dac_word_loader_bench.sv
// Purpose: end-to-end bench for host and converter ends
// Assumes: host divides i_mclk for the link clock
// Notes:   a second converter, without load input, sits on a bench-driven link
`timescale 1ns/1ns
module serial_dac_word_loader_bench;
	import ssdl_pkg::*;
	logic	i_mclk = 1'b0;
	logic	i_rst;
	logic [15:0]	i_data;
	logic [4:0]	i_nbits;
	logic	i_lsb_first;
	logic	i_valid;
	logic	i_byte_mode;
	logic	i_sync_load;
	logic	o_ready, o_busy, o_done, o_update, r_upd;
	logic [15:0]	o_code, r_code;
	logic [15:0]	exp_q[$];
	int	failures = 0;
	int	n_checks = 0;
	int	cyc = 0;
	int	n_done = 0;
	int	n_rupd = 0;
	ssdl_link_if link_if();
	ssdl_link_if raw_if();
	always #2 i_mclk = ~i_mclk;
	ssdl_host ssdl_host_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_data(i_data),
		.i_nbits(i_nbits), .i_lsb_first(i_lsb_first), .i_valid(i_valid),
		.o_ready(o_ready), .i_byte_mode(i_byte_mode), .i_sync_load(i_sync_load),
		.o_busy(o_busy), .o_done(o_done), .link(link_if.host));
	ssdl_dev ssdl_dev_i (.i_mclk(i_mclk), .i_rst(i_rst), .link(link_if.dev),
		.o_code(o_code), .o_update(o_update));
	ssdl_dev #(.HAS_LOAD(1'b0)) ssdl_dev_raw_i (.i_mclk(i_mclk), .i_rst(i_rst),
		.link(raw_if.dev), .o_code(r_code), .o_update(r_upd));
	ssdl_link_properties ssdl_link_properties_i (.i_mclk(i_mclk), .i_rst(i_rst),
		.sclk(link_if.sclk), .cs_n(link_if.cs_n), .din(link_if.din),
		.load_update_n(link_if.load_update_n));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 30000) begin
			failures++;
			conclude();
		end
	end
	// frame ends and updates of the second converter are counted mid-cycle
	always @(negedge i_mclk) begin
		if (o_done === 1'b1) begin
			n_done++;
		end
		if (r_upd === 1'b1) begin
			n_rupd++;
		end
	end
	// every update of the first converter must match the oldest word still expected
	always @(negedge i_mclk) begin
		if (o_update === 1'b1) begin
			chk(o_code, (exp_q.size() > 0) ? exp_q.pop_front() : 16'hXXXX);
		end
	end
	// valid stays up on return so back-to-back writes never glitch it
	task automatic put(input logic [15:0] d, input logic [4:0] n, input logic lf);
		i_data = d;
		i_nbits = n;
		i_lsb_first = lf;
		i_valid = 1'b1;
		@(negedge i_mclk);
		while (o_ready !== 1'b1) @(negedge i_mclk);
		@(posedge i_mclk);
		#1;
	endtask
	task automatic drain();
		i_valid = 1'b0;
		repeat (9000) begin
			@(negedge i_mclk);
			if (exp_q.size() == 0 && o_busy === 1'b0) break;
		end
		@(posedge i_mclk);
		#1;
		chk(16'(exp_q.size()), 16'h0000);
	endtask
	task automatic raw(input logic [19:0] v, input int n);
		raw_if.cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			raw_if.din = v[i];
			#40 raw_if.sclk = 1'b1;
			#40 raw_if.sclk = 1'b0;
		end
		#40 raw_if.cs_n = 1'b1;
		raw_if.din = ~raw_if.din;
		#200;
	endtask
	task automatic t_raw();
		raw(20'hF1234, 20);
		chk(r_code, 16'h1234);
		repeat (8) begin
			raw_if.din = ~raw_if.din;
			#40 raw_if.sclk = 1'b1;
			#40 raw_if.sclk = 1'b0;
		end
		chk(r_code, 16'h1234);
		chk(16'(n_rupd), 16'h0001);
		raw(20'h0000B, 4);
		chk(r_code, 16'h234B);
		chk(16'(n_rupd), 16'h0002);
		@(posedge i_mclk);
		#1;
	endtask
	task automatic t_word();
		exp_q.push_back(16'hA55A);
		exp_q.push_back(16'h8001);
		put(16'hA55A, 5'h10, 1'b0);
		put(16'h8001, 5'h00, 1'b0);
		drain();
		exp_q.push_back(16'hABC0);
		put(16'h0ABC, 5'h0C, 1'b0);
		drain();
		exp_q.push_back(16'h8000);
		put(16'h0001, 5'h08, 1'b1);
		drain();
	endtask
	task automatic t_modes();
		i_byte_mode = 1'b1;
		exp_q.push_back(16'h3C96);
		put(16'h3C96, 5'h10, 1'b0);
		drain();
		i_byte_mode = 1'b0;
		i_sync_load = 1'b1;
		exp_q.push_back(16'h1357);
		put(16'h1357, 5'h10, 1'b0);
		drain();
		i_sync_load = 1'b0;
	endtask
	task automatic t_fill();
		for (int i = 0; i < 10; i++) begin
			exp_q.push_back(16'(i) * 16'h1111);
			put(16'(i) * 16'h1111, 5'h10, 1'b0);
			if (i == 8) begin
				@(negedge i_mclk);
				chk({15'h0000, o_ready}, 16'h0000);
				#3;
			end
		end
		drain();
		chk(16'(n_done), 16'h0010);
	endtask
	initial begin
		i_rst = 1'b1;
		i_data = 16'h0000;
		i_nbits = 5'h10;
		i_lsb_first = 1'b0;
		i_valid = 1'b0;
		i_byte_mode = 1'b0;
		i_sync_load = 1'b0;
		raw_if.sclk = 1'b0;
		raw_if.cs_n = 1'b1;
		raw_if.din = 1'b0;
		raw_if.load_update_n = 1'b0;
		repeat (6) @(posedge i_mclk);
		#1 i_rst = 1'b0;
		chk(o_code, CODE_RESET);
		chk(r_code, CODE_RESET);
		t_raw();
		t_word();
		t_modes();
		t_fill();
		conclude();
	end
endmodule
